// ### rtl/ledd_serial_port.sv
// serial command port, digit planes and scan of the led display driver
//
// Behaviour
// - a command word is 16 bits, address in 15..8, data in 7..0
// - bit 15 arrives first and bit 0 last
// - with select low, data shifts in on each rising serial clock
// - with select high, serial clock and data are ignored
// - either serial clock idle level is accepted around a write
// - select rising copies the shift register to a latch, then executes
// - the port is write only, nothing is read back
// - a wrong bit count latches the last sixteen bits shifted
// - two planes of eight digit bytes are held
// - reset clears controls, blanks display, shuts down, scans five
// - the run bit chooses shutdown or normal operation
// - the rate bit selects between two blink rates
// - shutdown stops the scan and floats all outputs, data kept
// - writes work in shutdown; display test overrides shutdown
// - with blink on, the planes alternate on the display
// - a sync configuration write clears the scan and blink timing
// - a clear configuration write zeroes every digit in both planes
// - cleared decoded digits show zero, undecoded show nothing
// - scan limit takes up to eight digits; missing digits stay dark
// - pin n sinks digit n, others carry dp to b, pin 8 segment a
// - digit groups 0x20, 0x40, 0x60 write plane zero, one, both
// - configuration sits at 0x04 and resets to zero
`timescale 1ns/10ps
`include "ledd_defines.svh"
module ledd_serial_port #(
   parameter int DIGIT_COUNT = 5,
   parameter int DIGIT_TICKS = `LEDD_DIGIT_TICKS,
   parameter int BLINK_SLOW_BIT = `LEDD_BLINK_SLOW_BIT,
   parameter int BLINK_FAST_BIT = `LEDD_BLINK_FAST_BIT
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic serial_clk,
   input wire logic chip_select_n,
   input wire logic serial_data,
   output ledd_pkg::ledd_pins_t drive_out,
   output ledd_pkg::ledd_pins_t drive_oe,
   output logic [3:0] intensity_level
);
   import ledd_pkg::*;

   // ****************************************************************
   // serial clock side
   // ****************************************************************
   // no read path back
   ledd_word_t shift;
   ledd_word_t hold_word;
   logic cmd_toggle;

   // idle level irrelevant, only rises count
   // shifting only with select low keeps the shared lines harmless
   always_ff @(posedge serial_clk or negedge reset_n) begin
      if (!reset_n) begin
         shift <= 16'h0000;
      end else if (!chip_select_n) begin
         shift <= {shift[14:0], serial_data}; // msb first
      end
   end

   // whatever sixteen bits sit in the shifter are taken
   always_ff @(posedge chip_select_n or negedge reset_n) begin
      if (!reset_n) begin
         hold_word <= 16'h0000;
         cmd_toggle <= 1'b0;
      end else begin
         hold_word <= shift;
         cmd_toggle <= ~cmd_toggle;
      end
   end

   // ****************************************************************
   // crossing into the multiplex clock
   // ****************************************************************
   logic [2:0] tog_sync;
   logic cmd_event;
   ledd_word_t cmd_word;
   ledd_byte_t cmd_addr;
   ledd_byte_t cmd_data;

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         tog_sync <= 3'h0;
      end else begin
         tog_sync <= {tog_sync[1:0], cmd_toggle};
      end
   end

   assign cmd_event = tog_sync[1] ^ tog_sync[2];

   // held word is stable long before the toggle is seen
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         cmd_word <= 16'h0000;
      end else if (cmd_event) begin
         cmd_word <= hold_word;
      end
   end

   assign cmd_addr = hold_word[15:8];
   assign cmd_data = hold_word[7:0];

   // ****************************************************************
   // control registers
   // ****************************************************************
   ledd_byte_t display_configuration;
   ledd_byte_t decode_mode;
   logic [2:0] scan_limit;
   logic display_test;
   logic sync_req;
   logic clear_req;
   logic cfg_hit;

   assign cfg_hit = cmd_event && (cmd_addr == `LEDD_ADDR_CONFIG);
   assign sync_req = cfg_hit && cmd_data[`LEDD_CFG_SYNC_BIT];
   assign clear_req = cfg_hit && cmd_data[`LEDD_CFG_CLEAR_BIT];

   // other addresses fall through with no effect
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         display_configuration <= `LEDD_CONFIG_RESET;
         decode_mode <= `LEDD_DECODE_RESET;
         intensity_level <= `LEDD_INTENSITY_RESET;
         scan_limit <= `LEDD_SCAN_LIMIT_RESET;
         display_test <= 1'b0;
      end else if (cmd_event) begin
         case (cmd_addr)
            `LEDD_ADDR_CONFIG: display_configuration <= cmd_data;
            `LEDD_ADDR_DECODE: decode_mode <= cmd_data;
            `LEDD_ADDR_INTENSITY: intensity_level <= cmd_data[3:0];
            `LEDD_ADDR_SCAN_LIMIT: scan_limit <= cmd_data[2:0];
            `LEDD_ADDR_TEST: display_test <= cmd_data[`LEDD_TEST_BIT];
            default: ;
         endcase
      end
   end

   // ****************************************************************
   // digit planes
   // ****************************************************************
   ledd_byte_t plane_zero [8];
   ledd_byte_t plane_one [8];

   for (genvar i = 0; i < 8; i++) begin : g_digit
      logic hit;
      assign hit = cmd_event && (cmd_addr[2:0] == 3'(i));
      // clear wins over nothing else pending
      always_ff @(posedge ref_clk or negedge reset_n) begin
         if (!reset_n) begin
            plane_zero[i] <= `LEDD_DIGIT_RESET;
            plane_one[i] <= `LEDD_DIGIT_RESET;
         end else if (clear_req) begin
            plane_zero[i] <= `LEDD_DIGIT_RESET;
            plane_one[i] <= `LEDD_DIGIT_RESET;
         end else if (hit) begin
            if (cmd_addr[7:3] == `LEDD_GROUP_PLANE0 ||
                cmd_addr[7:3] == `LEDD_GROUP_BOTH) begin
               plane_zero[i] <= cmd_data;
            end
            if (cmd_addr[7:3] == `LEDD_GROUP_PLANE1 ||
                cmd_addr[7:3] == `LEDD_GROUP_BOTH) begin
               plane_one[i] <= cmd_data;
            end
         end
      end
   end

   // ****************************************************************
   // scan and blink timing
   // ****************************************************************
   ledd_mode_t mode;
   logic [15:0] slot_cnt;
   logic [2:0] scan_idx;
   logic [2:0] limit;
   logic [31:0] blink_cnt;
   logic blink_phase;

   always_comb begin
      if (display_test) begin
         mode = LEDD_TEST;
      end else if (display_configuration[`LEDD_CFG_RUN_BIT]) begin
         mode = LEDD_RUN;
      end else begin
         mode = LEDD_HALT;
      end
   end

   assign limit = (mode == LEDD_TEST) ? 3'h7 : scan_limit;

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         slot_cnt <= 16'h0000;
         scan_idx <= 3'h0;
         blink_cnt <= 32'h0000_0000;
      end else if (sync_req) begin
         slot_cnt <= 16'h0000;
         scan_idx <= 3'h0;
         blink_cnt <= 32'h0000_0000;
      end else if (mode != LEDD_HALT) begin
         blink_cnt <= blink_cnt + 32'h0000_0001;
         if (slot_cnt == 16'(DIGIT_TICKS - 1)) begin
            slot_cnt <= 16'h0000;
            scan_idx <= (scan_idx >= limit) ? 3'h0 : scan_idx + 3'h1;
         end else begin
            slot_cnt <= slot_cnt + 16'h0001;
         end
      end
   end

   assign blink_phase = display_configuration[`LEDD_CFG_RATE_BIT] ?
                        blink_cnt[BLINK_FAST_BIT] : blink_cnt[BLINK_SLOW_BIT];

   // ****************************************************************
   // segment decode and pin mapping
   // ****************************************************************
   // hex font, returns segments a..g
   function automatic logic [6:0] ledd_font(input logic [3:0] nib);
      case (nib)
         4'h0: ledd_font = 7'h7E;
         4'h1: ledd_font = 7'h30;
         4'h2: ledd_font = 7'h6D;
         4'h3: ledd_font = 7'h79;
         4'h4: ledd_font = 7'h33;
         4'h5: ledd_font = 7'h5B;
         4'h6: ledd_font = 7'h5F;
         4'h7: ledd_font = 7'h70;
         4'h8: ledd_font = 7'h7F;
         4'h9: ledd_font = 7'h7B;
         4'hA: ledd_font = 7'h77;
         4'hB: ledd_font = 7'h1F;
         4'hC: ledd_font = 7'h4E;
         4'hD: ledd_font = 7'h3D;
         4'hE: ledd_font = 7'h4F;
         default: ledd_font = 7'h47;
      endcase
   endfunction : ledd_font

   ledd_byte_t shown;
   ledd_byte_t segs;
   logic slot_live;
   wire ledd_pins_t next_out;
   wire ledd_pins_t next_oe;

   // decode of a zero byte shows zero
   always_comb begin
      if (display_configuration[`LEDD_CFG_BLINK_BIT] && blink_phase) begin
         shown = plane_one[scan_idx];
      end else begin
         shown = plane_zero[scan_idx];
      end
      if (mode == LEDD_TEST) begin
         segs = 8'hFF;
      end else if (decode_mode[scan_idx]) begin
         segs = {shown[7], ledd_font(shown[3:0])}; // dp, a..g
      end else begin
         segs = shown;
      end
   end

   // slots past the fitted digits stay dark
   assign slot_live = (mode != LEDD_HALT) && (32'(scan_idx) < DIGIT_COUNT);

   // pin n sinks, the rest carry dp,g,f,e,d,c,b; pin 8 is a
   for (genvar p = 0; p < 8; p++) begin : g_pin
      logic seg_on;
      logic pin_out;
      logic pin_oe;
      // modulo indexing keeps every select inside the segment byte
      always_comb begin
         if (p < scan_idx) begin
            seg_on = segs[(p + 7) % 8];
         end else begin
            seg_on = segs[(p + 6) % 8];
         end
         if (!slot_live) begin
            pin_out = 1'b0;
            pin_oe = 1'b0;
         end else if (3'(p) == scan_idx) begin
            pin_out = 1'b0; // digit_cathode_sink
            pin_oe = 1'b1;
         end else begin
            pin_out = seg_on;
            pin_oe = seg_on;
         end
      end
      assign next_out[p] = pin_out;
      assign next_oe[p] = pin_oe;
   end

   assign next_out[8] = slot_live && segs[6];
   assign next_oe[8] = slot_live && segs[6];

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         drive_out <= 9'h000;
         drive_oe <= 9'h000;
      end else begin
         drive_out <= next_out;
         drive_oe <= next_oe;
      end
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   logic planes_blank;
   always_comb begin
      planes_blank = 1'b1;
      for (int k = 0; k < 8; k++) begin
         if (plane_zero[k] != 8'h00 || plane_one[k] != 8'h00) begin
            planes_blank = 1'b0;
         end
      end
   end

   shift_order_a: assert property (
      @(posedge serial_clk) disable iff (!reset_n)
      !chip_select_n |=> shift == {$past(shift[14:0]), $past(serial_data)})
      else $error("shift register did not take msb first");

   cs_ignore_a: assert property (
      @(posedge serial_clk) disable iff (!reset_n)
      chip_select_n |=> $stable(shift))
      else $error("shift moved with select high");

   cmd_latch_a: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      cmd_event |=> cmd_word == $past(hold_word) && !cmd_event)
      else $error("synchronised command not captured once");

   cfg_write_a: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      cfg_hit |=> display_configuration == $past(cmd_data))
      else $error("configuration write lost");

   plane_clear_a: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      clear_req |=> planes_blank)
      else $error("digit clear left data");

   timing_sync_a: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      sync_req |=> slot_cnt == 16'h0000 && scan_idx == 3'h0)
      else $error("sync write did not clear timing");

   shutdown_float_a: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      mode == LEDD_HALT && !cmd_event
      |=> drive_oe == 9'h000 && $stable(slot_cnt) && $stable(blink_cnt))
      else $error("shutdown did not halt and float");

   noop_quiet_a: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      cmd_event && cmd_addr == `LEDD_ADDR_NOOP |=> $stable(planes_blank)
      && $stable(display_configuration) && $stable(decode_mode))
      else $error("no-op changed state");

   both_planes_a: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      cmd_event && cmd_addr == 8'h60 |=> plane_zero[0] == $past(cmd_data)
      && plane_one[0] == $past(cmd_data))
      else $error("both-plane write missed a plane");

   test_light_a: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      display_test && 32'(scan_idx) < DIGIT_COUNT |=> drive_oe == 9'h1FF)
      else $error("display test did not light");

endmodule : ledd_serial_port

// ### rtl/ledd_defines.svh
// register addresses, field positions, reset values and timing counts
`ifndef LEDD_DEFINES_SVH
`define LEDD_DEFINES_SVH
// ****************************************************************
// command addresses
// ****************************************************************
`define LEDD_ADDR_NOOP 8'h00
`define LEDD_ADDR_DECODE 8'h01
`define LEDD_ADDR_INTENSITY 8'h02
`define LEDD_ADDR_SCAN_LIMIT 8'h03
`define LEDD_ADDR_CONFIG 8'h04
`define LEDD_ADDR_TEST 8'h07
// upper five address bits of the digit groups, low three pick the digit
`define LEDD_GROUP_PLANE0 5'h04
`define LEDD_GROUP_PLANE1 5'h08
`define LEDD_GROUP_BOTH 5'h0C
// ****************************************************************
// field positions
// ****************************************************************
`define LEDD_CFG_RUN_BIT 0
`define LEDD_CFG_RATE_BIT 2
`define LEDD_CFG_BLINK_BIT 3
`define LEDD_CFG_SYNC_BIT 4
`define LEDD_CFG_CLEAR_BIT 5
`define LEDD_TEST_BIT 0
// ****************************************************************
// reset values
// ****************************************************************
`define LEDD_CONFIG_RESET 8'h00
`define LEDD_DECODE_RESET 8'h00
`define LEDD_INTENSITY_RESET 4'h0
`define LEDD_SCAN_LIMIT_RESET 3'h4
`define LEDD_DIGIT_RESET 8'h00
// ****************************************************************
// timing
// ****************************************************************
`define LEDD_CLK_PERIOD_NS 100
`define LEDD_DIGIT_SLOT_NS 40000
`define LEDD_DIGIT_TICKS (`LEDD_DIGIT_SLOT_NS / `LEDD_CLK_PERIOD_NS)
`define LEDD_BLINK_SLOW_BIT 22
`define LEDD_BLINK_FAST_BIT 21
`endif

// ### rtl/ledd_pkg.sv
// types shared by the serial command port
package ledd_pkg;
   typedef logic [7:0] ledd_byte_t;
   typedef logic [15:0] ledd_word_t;
   typedef logic [8:0] ledd_pins_t;
   typedef enum {LEDD_HALT, LEDD_RUN, LEDD_TEST} ledd_mode_t;
endpackage : ledd_pkg

// ### dv/ledd_host_model.sv
// host serial master model that writes command words to the port
`timescale 1ns/10ps
module ledd_host_model (
   output logic serial_clk,
   output logic chip_select_n,
   output logic serial_data
);
   // ************************************************************
   // frame sender
   // ************************************************************
   localparam realtime HALF = 7.5;
   // idle state: deselected, clock still
   initial begin
      serial_clk = 1'b0;
      chip_select_n = 1'b1;
      serial_data = 1'b0;
   end
   task automatic send(input logic [31:0] word, input int nbits,
      input logic idle_hi);
      serial_clk = idle_hi;
      #HALF chip_select_n = 1'b0;
      for (int i = nbits - 1; i >= 0; i--) begin
         serial_clk = 1'b0;
         serial_data = word[i];
         #HALF serial_clk = 1'b1;
         #HALF;
      end
      serial_clk = idle_hi;
      #HALF chip_select_n = 1'b1;
      serial_data = ~serial_data; // released line, stale value hidden
   endtask : send
   // traffic for another peripheral, select high
   task automatic stray(input int n);
      for (int i = 0; i < n; i++) begin
         serial_data = i[0];
         #HALF serial_clk = 1'b1;
         #HALF serial_clk = 1'b0;
      end
   endtask : stray
endmodule : ledd_host_model

// ### dv/tb_top.sv
// self-checking testbench of the led driver serial command port
`timescale 1ns/10ps
module tb_top;
   import ledd_pkg::*;
   localparam int LIMIT = 20000;
   logic ref_clk = 1'b0;
   logic reset_n = 1'b0;
   wire serial_clk;
   wire chip_select_n;
   wire serial_data;
   ledd_pins_t drive_out;
   ledd_pins_t drive_oe;
   logic [3:0] intensity_level;
   int errors = 0;
   int n_tests = 0;
   int cycles = 0;
   // multiplex clock, 100 ns
   always #50 ref_clk = ~ref_clk;
   ledd_host_model host (
      .serial_clk(serial_clk),
      .chip_select_n(chip_select_n),
      .serial_data(serial_data)
   );
   ledd_serial_port #(
      .DIGIT_COUNT(5),
      .DIGIT_TICKS(4),
      .BLINK_SLOW_BIT(4),
      .BLINK_FAST_BIT(3)
   ) dut (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .serial_clk(serial_clk),
      .chip_select_n(chip_select_n),
      .serial_data(serial_data),
      .drive_out(drive_out),
      .drive_oe(drive_oe),
      .intensity_level(intensity_level)
   );
   // ************************************************************
   // helpers
   // ************************************************************
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : test_done
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : tick
   task automatic check_int(input logic [3:0] act, input logic [3:0] exp);
      n_tests++;
      if (act !== exp) begin
         errors++;
         $display("[FAIL] %0t level %h expected %h", $time, act, exp);
      end
   endtask : check_int
   task automatic check_pins(input logic [17:0] act,
      input logic [17:0] exp);
      n_tests++;
      if (act !== exp) begin
         errors++;
         $display("[FAIL] %0t pins %h expected %h", $time, act, exp);
      end
   endtask : check_pins
   // one full command word, then time to execute
   task automatic cmd(input logic [7:0] addr, input logic [7:0] data);
      host.send({16'h0000, addr, data}, 16, 1'b0);
      tick(8);
   endtask : cmd
   // expected {out, oe} while digit d is scanned with byte b
   function automatic logic [17:0] pins_for(input int d,
      input logic [7:0] b);
      logic [6:0] segs;
      logic [8:0] o;
      logic [8:0] e;
      int k;
      segs = {b[5], b[4], b[3], b[2], b[1], b[0], b[7]};
      o = 9'h000;
      e = 9'h000;
      k = 0;
      for (int p = 0; p < 8; p++) begin
         if (p == d) begin
            e[p] = 1'b1;
         end else begin
            o[p] = segs[k];
            e[p] = segs[k];
            k++;
         end
      end
      o[8] = b[6];
      e[8] = b[6];
      return {o, e};
   endfunction : pins_for
   // wait for the slot of digit d, then compare the pins
   task automatic look(input int d, input logic [17:0] exp);
      for (int i = 0; i < 200; i++) begin
         if (drive_oe[d] === 1'b1 && drive_out[d] === 1'b0) break;
         tick(1);
      end
      check_pins({drive_out, drive_oe}, exp);
   endtask : look
   // every pin must stay floating and low for n cycles
   task automatic dark(input int n);
      logic [17:0] acc;
      acc = 18'h00000;
      repeat (n) begin
         tick(1);
         acc = acc | {drive_out, drive_oe};
      end
      check_pins(acc, 18'h00000);
   endtask : dark
   // digit d must never sink its cathode for n cycles
   task automatic absent(input int d, input int n);
      logic hit;
      hit = 1'b0;
      repeat (n) begin
         tick(1);
         hit = hit | (drive_oe[d] & ~drive_out[d]);
      end
      check_pins({17'h00000, hit}, 18'h00000);
   endtask : absent
   // digit d must show both a and b within a long window
   task automatic blink(input int d, input logic [17:0] a,
      input logic [17:0] b);
      logic [1:0] seen;
      seen = 2'h0;
      repeat (300) begin
         tick(1);
         if (drive_oe[d] === 1'b1 && drive_out[d] === 1'b0) begin
            if ({drive_out, drive_oe} === a) seen[0] = 1'b1;
            if ({drive_out, drive_oe} === b) seen[1] = 1'b1;
         end
      end
      check_pins({16'h0000, seen}, 18'h00003);
   endtask : blink
   // cuts a hang short
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == LIMIT) begin
         errors++;
         test_done();
      end
   end
   // ************************************************************
   // test sequence
   // ************************************************************
   initial begin
      repeat (12) @(posedge ref_clk);
      #1 reset_n = 1'b1;
      tick(2);
      // blank and shut down after reset
      check_int(intensity_level, 4'h0);
      dark(60);
      cmd(8'h02, 8'h0A);
      check_int(intensity_level, 4'hA);
      host.stray(20);
      tick(8);
      check_int(intensity_level, 4'hA);
      cmd(8'h00, 8'h03);
      check_int(intensity_level, 4'hA);
      cmd(8'h06, 8'h03);
      check_int(intensity_level, 4'hA);
      // long and short frames keep the last sixteen bits
      host.send({8'h00, 8'hA5, 16'h0205}, 24, 1'b0);
      tick(8);
      check_int(intensity_level, 4'h5);
      host.send(32'h00005502, 16, 1'b0);
      tick(8);
      check_int(intensity_level, 4'h5);
      host.send(32'h00000006, 8, 1'b0);
      tick(8);
      check_int(intensity_level, 4'h6);
      host.send(32'h00000209, 16, 1'b1);
      tick(8);
      check_int(intensity_level, 4'h9);
      cmd(8'h60, 8'h80);
      cmd(8'h41, 8'h40);
      cmd(8'h21, 8'h01);
      dark(60);
      cmd(8'h04, 8'h01);
      look(0, pins_for(0, 8'h80));
      look(1, pins_for(1, 8'h01));
      // both planes alternate at both rates
      cmd(8'h04, 8'h09);
      blink(1, pins_for(1, 8'h01), pins_for(1, 8'h40));
      cmd(8'h04, 8'h0D);
      blink(1, pins_for(1, 8'h01), pins_for(1, 8'h40));
      cmd(8'h04, 8'h00);
      dark(60);
      cmd(8'h07, 8'h01);
      look(2, pins_for(2, 8'hFF));
      cmd(8'h07, 8'h00);
      dark(60);
      cmd(8'h04, 8'h11);
      look(0, pins_for(0, 8'h80));
      // clear wipes both planes, decoded digit 0 shows zero
      cmd(8'h01, 8'h01);
      cmd(8'h04, 8'h29);
      blink(1, pins_for(1, 8'h00), pins_for(1, 8'h00));
      look(0, pins_for(0, 8'h7E));
      // scan limit narrows to one digit, then widens to eight
      cmd(8'h03, 8'h00);
      tick(8);
      absent(1, 60);
      cmd(8'h03, 8'h07);
      absent(6, 100);
      look(0, pins_for(0, 8'h7E));
      test_done();
   end
endmodule : tb_top
